/* File: rtl/ucrl_consts.vh */
`ifndef UCRL_CONSTS_VH
`define UCRL_CONSTS_VH
`define UCRL_A_DATA 3'h0
`define UCRL_A_IER 3'h1
`define UCRL_A_ISR 3'h2
`define UCRL_A_LCR 3'h3
`define UCRL_A_MCR 3'h4
`define UCRL_A_LSR 3'h5
`define UCRL_A_MSR 3'h6
`define UCRL_A_SPR 3'h7
`define UCRL_LCR_DIV 7
`define UCRL_MCR_LOOP 4
`define UCRL_MCR_RTS 1
`define UCRL_MCR_DTR 0
`define UCRL_FCR_EN 0
`define UCRL_FCR_RXRST 1
`define UCRL_FCR_TXRST 2
`define UCRL_REG_RST 8'h00
`define UCRL_IER_MASK 8'h0f
`define UCRL_AFR_MASK 8'h07
`define UCRL_MCR_MASK 8'h1f
`define UCRL_ISR_NONE 4'h1
`define UCRL_ISR_RXRDY 4'h4
`define UCRL_ISR_LINE 4'h6
`define UCRL_ISR_TXRDY 4'h2
`define UCRL_ISR_MODEM 4'h0
`define UCRL_BIT_LAST 4'hf
`define UCRL_HALF_LAST 4'h7
`define UCRL_FRAME_BITS 4'ha
`define UCRL_DLL_RST 8'h01
`endif

/* File: rtl/ucrl_fifo.v */
`timescale 1ns/100ps
`default_nettype none
module ucrl_fifo #(
	parameter WIDTH = 11,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset.
	input wire mclk,
	input wire sys_rst,
	input wire flush,
	// Fill side.
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side.
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_reg;
	reg [AW-1:0] rd_reg;
	reg [AW:0] cnt_reg;
	wire push;
	wire pop;
	assign in_ready = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_reg];
	assign level = cnt_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always @(posedge mclk) begin
		if (push)
			mem[wr_reg] <= in_data;
	end
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			if (push && !pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/ucrl_channel.v */
`timescale 1ns/100ps
`default_nettype none
`include "ucrl_consts.vh"
module ucrl_channel #(
	parameter DEPTH = 16,
	parameter AW = 4,
	parameter CHANNEL_ID = 1'b0
) (
	// Clock and reset.
	input wire mclk,
	input wire sys_rst,
	// Host bus.
	input wire cs_n,
	input wire channel_select,
	input wire [2:0] addr,
	input wire rd_n,
	input wire wr_n,
	input wire [7:0] wdata,
	output reg [7:0] rdata,
	// Serial and modem pins.
	input wire rx_pin,
	output reg tx_pin,
	output reg rts_n,
	output reg dtr_n,
	input wire cts_n,
	input wire dsr_n,
	input wire carrier_detect_n,
	input wire ring_indicator_n
);
	function [7:0] sync3;
		input [7:0] s2;
		input [7:0] s3;
		input [7:0] old;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1)
				sync3[i] = (s2[i] == s3[i]) ? s2[i] : old[i];
		end
	endfunction
	// Pin synchronisers, bits: rd, wr, rx, cts, dsr, cd, ri, cs.
	wire [7:0] raw_in;
	reg [7:0] s1_reg, s2_reg, s3_reg, in_reg;
	assign raw_in = {!(cs_n == 1'b0 && channel_select == CHANNEL_ID),
		ring_indicator_n, carrier_detect_n, dsr_n, cts_n, rx_pin, wr_n, rd_n};
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg <= 8'hff;
			s2_reg <= 8'hff;
			s3_reg <= 8'hff;
			in_reg <= 8'hff;
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			in_reg <= sync3(s2_reg, s3_reg, in_reg);
		end
	end
	reg [7:0] in_d_reg;
	reg [2:0] addr_reg;
	reg [7:0] wd_reg;
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			in_d_reg <= 8'hff;
			addr_reg <= 3'h0;
			wd_reg <= 8'h00;
		end else begin
			in_d_reg <= in_reg;
			addr_reg <= addr;
			wd_reg <= wdata;
		end
	end
	wire sel = !in_reg[7];
	wire rd_pulse = sel && !in_reg[0] && in_d_reg[0];
	wire wr_pulse = sel && !in_reg[1] && in_d_reg[1];
	// Registers.
	reg [7:0] ier_reg, lcr_reg, mcr_reg, spr_reg, dll_reg, dlm_reg, afr_reg;
	reg fifo_en_reg, txs_reg;
	reg [7:0] msr_reg;
	wire loop = mcr_reg[`UCRL_MCR_LOOP];
	wire dlab = lcr_reg[`UCRL_LCR_DIV];
	wire wr_data = wr_pulse && addr_reg == `UCRL_A_DATA && !dlab;
	wire rd_data = rd_pulse && addr_reg == `UCRL_A_DATA && !dlab;
	wire wr_fcr = wr_pulse && addr_reg == `UCRL_A_ISR && !dlab;
	wire rxflush = wr_fcr && wd_reg[`UCRL_FCR_EN] && wd_reg[`UCRL_FCR_RXRST];
	wire txflush = wr_fcr && wd_reg[`UCRL_FCR_EN] && wd_reg[`UCRL_FCR_TXRST];
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ier_reg <= `UCRL_REG_RST;
			lcr_reg <= `UCRL_REG_RST;
			mcr_reg <= `UCRL_REG_RST;
			spr_reg <= `UCRL_REG_RST;
			dll_reg <= `UCRL_DLL_RST;
			dlm_reg <= `UCRL_REG_RST;
			afr_reg <= `UCRL_REG_RST;
			fifo_en_reg <= 1'b0;
		end else if (wr_pulse) begin
			case (addr_reg)
			`UCRL_A_DATA: if (dlab) dll_reg <= wd_reg;
			`UCRL_A_IER: begin
				if (dlab)
					dlm_reg <= wd_reg;
				else
					ier_reg <= wd_reg & `UCRL_IER_MASK;
			end
			`UCRL_A_ISR: begin
				if (dlab)
					afr_reg <= wd_reg & `UCRL_AFR_MASK;
				else
					fifo_en_reg <= wd_reg[`UCRL_FCR_EN];
			end
			`UCRL_A_LCR: lcr_reg <= wd_reg;
			`UCRL_A_MCR: mcr_reg <= wd_reg & `UCRL_MCR_MASK;
			`UCRL_A_SPR: spr_reg <= wd_reg;
			default: ;
			endcase
		end
	end
	// Transmit queue and shifter.
	wire tq_valid;
	wire [10:0] tq_data;
	wire [AW:0] tq_level;
	reg tq_pop;
	ucrl_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_txq (
		.mclk(mclk), .sys_rst(sys_rst), .flush(txflush),
		.in_valid(wr_data), .in_ready(),
		.in_data({3'h0, wd_reg}),
		.out_valid(tq_valid), .out_ready(tq_pop), .out_data(tq_data),
		.level(tq_level)
	);
	reg [15:0] bdiv_reg;
	reg [3:0] tick16_reg;
	reg tick_reg;
	wire [15:0] divisor = {dlm_reg, dll_reg};
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bdiv_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (bdiv_reg + 16'h0001 >= divisor) begin
			bdiv_reg <= 16'h0000;
			tick_reg <= 1'b1;
		end else begin
			bdiv_reg <= bdiv_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end
	reg [9:0] tsh_reg;
	reg [3:0] tbit_reg;
	reg [3:0] tcnt_reg;
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tsh_reg <= 10'h3ff;
			tbit_reg <= 4'h0;
			tcnt_reg <= 4'h0;
			tq_pop <= 1'b0;
			txs_reg <= 1'b1;
		end else begin
			tq_pop <= 1'b0;
			if (tbit_reg == 4'h0) begin
				if (tq_valid && !tq_pop) begin
					tsh_reg <= {1'b1, tq_data[7:0], 1'b0};
					tbit_reg <= `UCRL_FRAME_BITS;
					tcnt_reg <= 4'h0;
					tq_pop <= 1'b1;
				end
			end else if (tick_reg) begin
				if (tcnt_reg == `UCRL_BIT_LAST) begin
					tsh_reg <= {1'b1, tsh_reg[9:1]};
					tbit_reg <= tbit_reg - 4'h1;
				end
				tcnt_reg <= tcnt_reg + 4'h1;
			end
			txs_reg <= tsh_reg[0];
		end
	end
	// Receiver; in loopback it listens to the transmit shifter.
	wire rx_line = loop ? txs_reg : in_reg[2];
	reg [3:0] rbit_reg;
	reg [3:0] rcnt_reg;
	reg [8:0] rsh_reg;
	reg rq_push;
	reg [10:0] rq_in;
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rbit_reg <= 4'h0;
			rcnt_reg <= 4'h0;
			rsh_reg <= 9'h000;
			rq_push <= 1'b0;
			rq_in <= 11'h000;
		end else begin
			rq_push <= 1'b0;
			if (rbit_reg == 4'h0) begin
				if (!rx_line) begin
					rbit_reg <= `UCRL_FRAME_BITS;
					rcnt_reg <= 4'h0;
				end
			end else if (tick_reg) begin
				rcnt_reg <= rcnt_reg + 4'h1;
				if (rcnt_reg == `UCRL_HALF_LAST) begin
					rsh_reg <= {rx_line, rsh_reg[8:1]};
					rbit_reg <= rbit_reg - 4'h1;
					if (rbit_reg == `UCRL_FRAME_BITS && rx_line)
						rbit_reg <= 4'h0;
					if (rbit_reg == 4'h1) begin
						rq_push <= 1'b1;
						// Tags: break, framing, parity (parity unused).
						rq_in <= {!rx_line && rsh_reg[8:1] == 8'h00,
							!rx_line, 1'b0, rsh_reg[8:1]};
					end
				end
			end
		end
	end
	wire rq_valid;
	wire [10:0] rq_head;
	wire [AW:0] rq_level;
	wire rq_ready;
	reg ovr_reg;
	ucrl_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_rxq (
		.mclk(mclk), .sys_rst(sys_rst), .flush(rxflush),
		.in_valid(rq_push), .in_ready(rq_ready), .in_data(rq_in),
		.out_valid(rq_valid), .out_ready(rd_data),
		.out_data(rq_head), .level(rq_level)
	);
	// Modem status, inputs ignored during loopback.
	wire [3:0] mdm = loop ? {mcr_reg[3], mcr_reg[2], mcr_reg[0], mcr_reg[1]}
		: ~in_reg[6:3];
	wire [7:0] line_status = {1'b0, tbit_reg == 4'h0 && !tq_valid, !tq_valid,
		rq_valid ? rq_head[10:8] : 3'h0, ovr_reg, rq_valid};
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			msr_reg <= 8'h00;
			ovr_reg <= 1'b0;
		end else begin
			msr_reg[7:4] <= {mdm[2], mdm[3], mdm[1], mdm[0]};
			msr_reg[3:0] <= (rd_pulse && addr_reg == `UCRL_A_MSR ?
				4'h0 : msr_reg[3:0]) |
				({mdm[2], mdm[3], mdm[1], mdm[0]} ^ msr_reg[7:4]);
			if (rq_push && !rq_ready)
				ovr_reg <= 1'b1;
			else if (rd_pulse && addr_reg == `UCRL_A_LSR)
				ovr_reg <= 1'b0;
		end
	end
	reg [3:0] interrupt_status;
	always @* begin
		interrupt_status = `UCRL_ISR_NONE;
		if (ier_reg[2] && line_status[4:1] != 4'h0)
			interrupt_status = `UCRL_ISR_LINE;
		else if (ier_reg[0] && rq_valid)
			interrupt_status = `UCRL_ISR_RXRDY;
		else if (ier_reg[1] && !tq_valid)
			interrupt_status = `UCRL_ISR_TXRDY;
		else if (ier_reg[3] && msr_reg[3:0] != 4'h0)
			interrupt_status = `UCRL_ISR_MODEM;
	end
	// Read mux and pins, all registered.
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata <= 8'h00;
			tx_pin <= 1'b1;
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end else begin
			tx_pin <= loop ? 1'b1 : txs_reg;
			rts_n <= loop ? 1'b1 : !mcr_reg[`UCRL_MCR_RTS];
			dtr_n <= loop ? 1'b1 : !mcr_reg[`UCRL_MCR_DTR];
			if (rd_pulse) begin
				case (addr_reg)
				`UCRL_A_DATA: rdata <= dlab ? dll_reg : rq_head[7:0];
				`UCRL_A_IER: rdata <= dlab ? dlm_reg : ier_reg;
				`UCRL_A_ISR: rdata <= dlab ? afr_reg :
					{{2{fifo_en_reg}}, 2'b00, interrupt_status};
				`UCRL_A_LCR: rdata <= lcr_reg;
				`UCRL_A_MCR: rdata <= mcr_reg;
				`UCRL_A_LSR: rdata <= line_status;
				`UCRL_A_MSR: rdata <= msr_reg;
				`UCRL_A_SPR: rdata <= spr_reg;
				default: rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* File: dv/ucrl_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module ucrl_chk (
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Host bus.
	input wire logic cs_n,
	input wire logic channel_select,
	input wire logic [2:0] addr,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	// Line and modem outputs.
	input wire logic tx_pin,
	input wire logic rts_n,
	input wire logic dtr_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [7:0] spr_q, lcr_q, mcr_q, dll_q;
	wire sel = !cs_n && !channel_select;
	// Shadow copies of the scratch, line control, modem control and divisor low registers, taken at the end of a write.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			spr_q <= 8'h00;
			lcr_q <= 8'h00;
			mcr_q <= 8'h00;
			dll_q <= 8'h01;
		end else if ($rose(wr_n) && sel) begin
			case (addr)
			3'h0: if (lcr_q[7]) dll_q <= wdata;
			3'h3: lcr_q <= wdata;
			3'h4: mcr_q <= wdata & 8'h1f;
			3'h7: spr_q <= wdata;
			default: ;
			endcase
		end
	end
	spr_read_a: assert property (
		$rose(rd_n) && sel && addr == 3'h7 |-> rdata == spr_q)
		else $error("scratch read wrong");
	lcr_read_a: assert property (
		$rose(rd_n) && sel && addr == 3'h3 |-> rdata == lcr_q)
		else $error("line control read wrong");
	mcr_read_a: assert property (
		$rose(rd_n) && sel && addr == 3'h4 |-> rdata == mcr_q)
		else $error("modem control read wrong");
	dll_read_a: assert property (
		$rose(rd_n) && sel && addr == 3'h0 && lcr_q[7] |-> rdata == dll_q)
		else $error("divisor low read wrong");
	rdata_hold_a: assert property (
		$changed(rdata) |-> !rd_n)
		else $error("read data moved without a read");
	loop_tx_a: assert property (
		wr_n && $stable(wr_n) && mcr_q[4] |-> tx_pin)
		else $error("serial output not at mark in loopback");
	loop_ctl_a: assert property (
		wr_n && $stable(wr_n) && mcr_q[4] |-> rts_n && dtr_n)
		else $error("modem outputs asserted in loopback");
	mcr_out_a: assert property (
		wr_n && $stable(wr_n) && !mcr_q[4]
		|-> rts_n == !mcr_q[1] && dtr_n == !mcr_q[0])
		else $error("modem outputs do not follow control");
endmodule
bind ucrl_channel ucrl_chk u_chk (.mclk, .sys_rst, .cs_n,
	.channel_select, .addr, .rd_n, .wr_n, .wdata, .rdata, .tx_pin,
	.rts_n, .dtr_n);
`default_nettype wire

/* File: dv/ucrl_host.sv */
`timescale 1ns/100ps
`default_nettype none
module ucrl_host (
	// Clock.
	input wire logic mclk,
	// Register bus.
	output logic cs_n,
	output logic channel_select,
	output logic [2:0] addr,
	output logic rd_n,
	output logic wr_n,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata,
	// Line input and read result.
	output logic rx_pin,
	output logic done,
	output logic [7:0] got
);
	assign rx_pin = 1'b1;
	initial begin
		cs_n = 1'b1;
		channel_select = 1'b0;
		addr = 3'h0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		wdata = 8'h00;
		done = 1'b0;
		got = 8'h00;
	end
	task automatic access(input logic wr, input logic ch,
		input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		cs_n = 1'b0;
		channel_select = ch;
		addr = a;
		wdata = d;
		rd_n = wr;
		wr_n = !wr;
		repeat (8) @(posedge mclk);
		got = rdata;
		#1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		done = !wr && !ch;
		@(posedge mclk);
		#1;
		done = 1'b0;
		cs_n = 1'b1;
		addr = ~a;
		wdata = ~d;
		repeat (5) @(posedge mclk);
		#1;
	endtask
endmodule
`default_nettype wire

/* File: dv/uart_channel_regmap_loopback_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module uart_channel_regmap_loopback_bench;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic cs_n, channel_select, rd_n, wr_n, rx_pin, done;
	logic tx_pin, rts_n, dtr_n;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, got, v;
	logic [3:0] modem_n = 4'hf;
	logic [15:0] exp_q[$];
	logic [15:0] note;
	logic [7:0] sent[$];
	int err_count = 0;
	int checks_done = 0;
	always #10 mclk = ~mclk;
	ucrl_channel DUT (.mclk, .sys_rst, .cs_n, .channel_select, .addr,
		.rd_n, .wr_n, .wdata, .rdata, .rx_pin, .tx_pin, .rts_n, .dtr_n,
		.cts_n(modem_n[0]), .dsr_n(modem_n[1]),
		.carrier_detect_n(modem_n[2]), .ring_indicator_n(modem_n[3]));
	ucrl_host host (.mclk, .cs_n, .channel_select, .addr, .rd_n, .wr_n,
		.wdata, .rdata, .rx_pin, .done, .got);
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host.access(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] m,
		input logic [7:0] e);
		exp_q.push_back({m, e & m});
		host.access(1'b0, 1'b0, a, 8'h00);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Compares each finished read with the oldest expectation.
	always @(posedge mclk) begin
		if (done === 1'b1) begin
			note = exp_q.pop_front();
			checks_done++;
			if ((got & note[15:8]) !== note[7:0]) begin
				err_count++;
				$display("[FAIL] %0t got %h exp %h", $time,
					got & note[15:8], note[7:0]);
			end
		end
	end
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		complete_run;
	end
	initial begin
		void'($urandom(32'h66eba50e));
		repeat (4) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		rd(3'h7, 8'hff, 8'h00);
		rd(3'h1, 8'hff, 8'h00);
		v = $urandom;
		wr(3'h7, v);
		host.access(1'b1, 1'b1, 3'h7, ~v);
		wr(3'h5, 8'hff);
		wr(3'h6, 8'hff);
		rd(3'h7, 8'hff, v);
		rd(3'h5, 8'h61, 8'h60);
		wr(3'h1, v);
		rd(3'h1, 8'hff, v & 8'h0f);
		wr(3'h4, v & 8'h0f);
		rd(3'h4, 8'hff, v & 8'h0f);
		wr(3'h3, v | 8'h80);
		rd(3'h3, 8'hff, v | 8'h80);
		for (int i = 0; i < 3; i++) begin
			wr(i[2:0], v + i[7:0]);
			rd(i[2:0], (i == 2) ? 8'h07 : 8'hff, v + i[7:0]);
		end
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h00);
		wr(3'h3, 8'h03);
		$display("test registers done");
		wr(3'h2, 8'h01);
		rd(3'h2, 8'hc0, 8'hc0);
		wr(3'h4, 8'h13);
		for (int i = 0; i < 17; i++) begin
			v = $urandom;
			sent.push_back(v);
			wr(3'h0, v);
			modem_n = $urandom;
		end
		repeat (3000) @(posedge mclk);
		#1;
		rd(3'h5, 8'h1f, 8'h03);
		rd(3'h6, 8'hf0, 8'h30);
		for (int i = 0; i < 16; i++) begin
			rd(3'h5, 8'h1d, 8'h01);
			rd(3'h0, 8'hff, sent[i]);
		end
		rd(3'h5, 8'h01, 8'h00);
		wr(3'h0, 8'h5a);
		wr(3'h0, 8'ha5);
		repeat (500) @(posedge mclk);
		#1;
		rd(3'h5, 8'h01, 8'h01);
		wr(3'h2, 8'h03);
		rd(3'h5, 8'h01, 8'h00);
		wr(3'h4, 8'h00);
		$display("test loopback done");
		complete_run;
	end
endmodule
`default_nettype wire
